// *** src/adc_seq_core.sv ***
`timescale 1ns/100ps
`include "adc_seq_consts.svh"
module adc_seq_core
    import adc_seq_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        six_input_part,
    input  wire logic        converter_power_disable,
    input  wire logic        rc_clock_tick,
    input  wire logic        sample_start,
    input  wire logic        trigger_event,
    input  wire logic        conversion_done,
    output logic      [5:0]  pin_digital,
    output logic      [5:0]  port_read_enable,
    output logic      [5:0]  mux_grounded,
    output logic             conv_clock_tick,
    output logic             end_sample,
    output route_type        route,
    output logic      [5:0]  scan_list,
    output logic      [4:0]  scan_selected,
    output logic             scan_low_ref,
    output logic             irq
);
    logic [15:0] seq_q, seq_d, tim_q, tim_d, aux_q, aux_d;
    logic [15:0] main_q, main_d, scan_q, scan_d, pin_q, pin_d;
    logic [15:0] mode_q, mode_d, stat_q, stat_d, mask_q, mask_d;
    logic [15:0] rdata_d;
    logic [7:0]  div_cnt_q, div_cnt_d;
    logic [4:0]  smp_cnt_q, smp_cnt_d;
    logic [3:0]  seq_cnt_q, seq_cnt_d;
    logic [2:0]  scan_idx_q, scan_idx_d;
    logic        alt_q, alt_d;
    phase_type   phase_q, phase_d;
    route_type   route_q, route_d;
    logic [5:0]  pin_q6_q, pin_d6;
    logic [5:0]  port_q, mux_q;

    // mode register: bit 7 twelve-bit, 6:4 trigger, 3 alternate
    wire        twelve_bit_mode = mode_q[7];
    wire [2:0]  conversion_trigger_source = mode_q[6:4];
    wire        alternate_sample = mode_q[3];
    wire        scan_enable = seq_q[10];
    wire [1:0]  channel_count_select = seq_q[9:8];
    wire [3:0]  sequences_per_interrupt = seq_q[5:2];
    wire        internal_rc_clock_select = tim_q[15];
    wire [4:0]  auto_sample_duration = tim_q[12:8];
    wire [7:0]  conversion_clock_divisor = tim_q[7:0];
    wire        use_b = alternate_sample & alt_q;
    wire [1:0]  aux_neg = use_b ? aux_q[10:9] : aux_q[2:1];
    wire        aux_pos = use_b ? aux_q[8] : aux_q[0];
    wire [4:0]  main_pos = use_b ? main_q[12:8] : main_q[4:0];
    wire [2:0]  n_inputs = six_input_part ? `INPUTS_LARGE
                                          : `INPUTS_SMALL;
    wire [5:0]  present = six_input_part ? 6'h3f : 6'h0f;
    wire [5:0]  pin_cfg = pin_q[5:0] | ~present;
    wire [5:0]  digital = converter_power_disable ? 6'h3f
                                                  : pin_cfg;
    wire        wr_seq  = wr && addr == `ADDR_SEQ_CTRL;
    wire        wr_tim  = wr && addr == `ADDR_TIMING;
    wire        wr_aux  = wr && addr == `ADDR_AUX_SEL;
    wire        wr_main = wr && addr == `ADDR_MAIN_SEL;
    wire        wr_scan = wr && addr == `ADDR_SCAN_SEL;
    wire        wr_pin  = wr && addr == `ADDR_PIN_CFG;
    wire        wr_mode = wr && addr == `ADDR_MODE_CTRL;
    wire        wr_mask = wr && addr == `ADDR_IRQ_MASK;
    wire        rd_stat = rd && addr == `ADDR_IRQ_STATUS;
    wire        div_reserved = conversion_clock_divisor > `DIV_MAX_VALID;
    wire        sys_tick = (div_cnt_q == conversion_clock_divisor)
                           && !div_reserved;
    wire        conversion_clock_period = internal_rc_clock_select ? rc_clock_tick
                                               : sys_tick;
    wire        auto_mode = conversion_trigger_source == `TRIG_AUTO;
    wire        smp_over = auto_mode
                    ? (smp_cnt_q == auto_sample_duration)
                    : trigger_event;
    wire        seq_end = phase_q == ph_convert && conversion_done;
    wire        irq_event = seq_end
                    && seq_cnt_q == sequences_per_interrupt;
    wire        scan_miss = scan_idx_q >= n_inputs;
    wire [2:0]  scan_next = (scan_idx_q == 3'h5) ? 3'h0
                                                 : scan_idx_q + 3'h1;

    // writes store only implemented bits; reads of holes give zero
    assign seq_d  = wr_seq  ? (wdata & `MASK_SEQ_CTRL)
                            : seq_q;
    assign tim_d  = wr_tim  ? (wdata & `MASK_TIMING) : tim_q;
    assign aux_d  = wr_aux  ? (wdata & `MASK_AUX_SEL) : aux_q;
    assign main_d = wr_main ? (wdata & `MASK_MAIN_SEL) : main_q;
    assign scan_d = wr_scan ? (wdata & `MASK_SIX_BITS) : scan_q;
    assign pin_d  = wr_pin  ? (wdata & `MASK_SIX_BITS) : pin_q;
    assign mode_d = wr_mode ? (wdata & `MASK_MODE_CTRL) : mode_q;
    assign mask_d = wr_mask ? (wdata & `MASK_IRQ) : mask_q;
    // set wins over the read-clear
    assign stat_d = ((rd_stat ? 16'h0_000 : stat_q)
                    | {14'h0_000, scan_miss && seq_end, irq_event});
    assign div_cnt_d = (sys_tick || div_reserved) ? 8'h0_0
                                                  : div_cnt_q + 8'h0_1;

    // channel count reads zero while in twelve-bit mode
    wire [15:0] seq_rd = twelve_bit_mode ? (seq_q & 16'hf_cff)
                                         : seq_q;
    assign rdata_d =
        !rd                          ? 16'h0_000 :
        (addr == `ADDR_SEQ_CTRL)     ? seq_rd :
        (addr == `ADDR_TIMING)       ? tim_q :
        (addr == `ADDR_AUX_SEL)      ? aux_q :
        (addr == `ADDR_MAIN_SEL)     ? main_q :
        (addr == `ADDR_SCAN_SEL)     ? scan_q :
        (addr == `ADDR_PIN_CFG)      ? pin_q :
        (addr == `ADDR_MODE_CTRL)    ? mode_q :
        (addr == `ADDR_IRQ_STATUS)   ? stat_q :
        (addr == `ADDR_IRQ_MASK)     ? mask_q : 16'h0_000;

    // phase sequencer
    always_comb begin
        phase_d   = phase_q;
        smp_cnt_d = smp_cnt_q;
        seq_cnt_d = seq_cnt_q;
        alt_d     = alt_q;
        scan_idx_d = scan_idx_q;
        case (phase_q)
            ph_idle: begin
                smp_cnt_d = 5'h0_0;
                if (sample_start && !converter_power_disable) begin
                    phase_d = ph_sample;
                end
            end
            ph_sample: begin
                if (smp_over) begin
                    phase_d = ph_convert;
                end else if (conversion_clock_period) begin
                    smp_cnt_d = smp_cnt_q + 5'h0_1;
                end
            end
            ph_convert: begin
                if (conversion_done) begin
                    phase_d = ph_idle;
                    alt_d = ~alt_q;
                    scan_idx_d = scan_next;
                    seq_cnt_d = irq_event ? 4'h0
                                          : seq_cnt_q + 4'h1;
                end
            end
            default: phase_d = ph_idle;
        endcase
    end

    // input routing
    always_comb begin
        route_d = '0;
        route_d.channels = twelve_bit_mode ? 3'h1 :
            channel_count_select[1] ? 3'h4 :
            channel_count_select[0] ? 3'h2 : 3'h1;
        route_d.pos0 = (scan_enable && scan_q[scan_idx_q])
            ? (scan_miss ? `SEL_LOW_REF
                         : {2'h0, scan_idx_q})
            : main_pos;
        if (!scan_enable && main_pos >= {2'h0, n_inputs}) begin
            route_d.pos0 = `SEL_NONE;
        end
        route_d.pos1 = `SEL_NONE;
        route_d.pos2 = `SEL_NONE;
        route_d.pos3 = `SEL_NONE;
        if (!twelve_bit_mode) begin
            route_d.aux_neg_low_ref = !aux_neg[1];
            if (!aux_pos) begin
                route_d.pos1 = 5'h0_0;
                route_d.pos2 = 5'h0_1;
                route_d.pos3 = 5'h0_2;
            end else if (six_input_part) begin
                route_d.pos1 = 5'h0_3;
                route_d.pos2 = 5'h0_4;
                route_d.pos3 = 5'h0_5;
            end else begin
                route_d.pos1 = 5'h0_3;
            end
        end
    end

    assign pin_d6 = digital;

    always_ff @(posedge clock) begin
        if (rst) begin
            seq_q <= '0;
            tim_q <= '0;
            aux_q <= '0;
            main_q <= '0;
            scan_q <= '0;
            pin_q <= '0;
            mode_q <= '0;
            stat_q <= '0;
            mask_q <= '0;
            rdata <= '0;
            div_cnt_q <= '0;
            smp_cnt_q <= '0;
            seq_cnt_q <= '0;
            scan_idx_q <= '0;
            alt_q <= 1'b0;
            phase_q <= ph_idle;
            route_q <= '0;
            pin_q6_q <= 6'h3f;
            port_q <= 6'h3f;
            mux_q <= 6'h3f;
        end else begin
            seq_q <= seq_d;
            tim_q <= tim_d;
            aux_q <= aux_d;
            main_q <= main_d;
            scan_q <= scan_d;
            pin_q <= pin_d;
            mode_q <= mode_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata <= rdata_d;
            div_cnt_q <= div_cnt_d;
            smp_cnt_q <= smp_cnt_d;
            seq_cnt_q <= seq_cnt_d;
            scan_idx_q <= scan_idx_d;
            alt_q <= alt_d;
            phase_q <= phase_d;
            route_q <= route_d;
            pin_q6_q <= pin_d6;
            port_q <= pin_d6;
            mux_q <= pin_d6;
        end
    end

    assign pin_digital = pin_q6_q;
    assign port_read_enable = port_q;
    assign mux_grounded = mux_q;
    assign conv_clock_tick = conversion_clock_period;
    assign end_sample = phase_q == ph_sample && smp_over;
    assign route = route_q;
    assign scan_list = scan_q[5:0];
    assign scan_selected = route_q.pos0;
    assign scan_low_ref = route_q.pos0 == `SEL_LOW_REF;
    assign irq = |(stat_q & mask_q);
endmodule : adc_seq_core

// *** common/adc_seq_consts.svh ***
// How it works
// - channel count picks one, two or four channels
// - scan bits add inputs to the scan list
// - missing scanned input converts low reference
// - aux negative codes 0x pick low reference
// - six-input part: aux select routes inputs 3..5
// - four-input part: aux select routes input 3 only
// - aux select zero routes inputs 0..2
// - main select code picks input by index
// - digital pin: read enabled, mux grounded
// - analog pin: read disabled, pin sampled
// - config bits stored even for missing inputs
// - power disable forces all pins digital
// - rc clock select ignores the divisor
// - unimplemented bits ignore writes, read zero
// - twelve-bit mode selects single channel operation
// - trigger 111 lets auto-sample counter end sampling
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define ADDR_SEQ_CTRL    4'h0
`define ADDR_TIMING      4'h1
`define ADDR_AUX_SEL     4'h2
`define ADDR_MAIN_SEL    4'h3
`define ADDR_SCAN_SEL    4'h4
`define ADDR_PIN_CFG     4'h5
`define ADDR_MODE_CTRL   4'h6
`define ADDR_IRQ_STATUS  4'h7
`define ADDR_IRQ_MASK    4'h8
`define MASK_SEQ_CTRL    16'h0_73f
`define MASK_TIMING      16'h9_fff
`define MASK_AUX_SEL     16'h0_707
`define MASK_MAIN_SEL    16'h9_f9f
`define MASK_SIX_BITS    16'h0_03f
`define MASK_MODE_CTRL   16'h0_0ff
`define MASK_IRQ         16'h0_003
`define TRIG_AUTO        3'h7
`define DIV_MAX_VALID    8'h3f
`define INPUTS_SMALL     3'h4
`define INPUTS_LARGE     3'h6
`define SEL_LOW_REF      5'h1f
`define SEL_NONE         5'h1e
`endif

// *** common/adc_seq_pkg.sv ***
package adc_seq_pkg;
    typedef struct packed {
        logic [4:0] pos0;
        logic [4:0] pos1;
        logic [4:0] pos2;
        logic [4:0] pos3;
        logic       aux_neg_low_ref;
        logic [2:0] channels;
    } route_type;
    typedef enum logic [1:0] {
        ph_idle,
        ph_sample,
        ph_convert
    } phase_type;
endpackage : adc_seq_pkg

// *** tb/adc_seq_core_props.sv ***
`timescale 1ns/100ps
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        converter_power_disable,
    input wire logic [5:0]  pin_digital,
    input wire logic [5:0]  port_read_enable,
    input wire logic [5:0]  mux_grounded,
    input wire route_type   route,
    input wire logic        irq
);
    logic twelve_q;
    logic mask_q;
    // shadow copies of mode and mask, enough to judge route and irq
    always_ff @(posedge clock) begin
        if (rst) begin
            twelve_q <= 1'b0;
            mask_q   <= 1'b0;
        end else if (wr) begin
            if (addr == 4'h6) twelve_q <= wdata[7];
            if (addr == 4'h8) mask_q <= |wdata[1:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_read_enable_match: assert property (port_read_enable == pin_digital)
        else $error("port read enable differs from pin mode");
    a_mux_ground_match: assert property (mux_grounded == pin_digital)
        else $error("mux ground differs from pin mode");
    a_power_all_digital: assert property (
        converter_power_disable |=> pin_digital == 6'h3f)
        else $error("pins not digital while powered off");
    a_scan_pin_upper: assert property (
        rd && (addr == 4'h4 || addr == 4'h5) |=> rdata[15:6] == 10'h000)
        else $error("unimplemented scan or pin bits read nonzero");
    a_aux_upper_zero: assert property (
        rd && addr == 4'h2 |=> (rdata & 16'hf8f8) == 16'h0000)
        else $error("unimplemented aux select bits read nonzero");
    a_main_upper_zero: assert property (
        rd && addr == 4'h3 |=> (rdata & 16'h6060) == 16'h0000)
        else $error("unimplemented main select bits read nonzero");
    a_twelve_one_channel: assert property (
        twelve_q && $past(twelve_q) |-> route.channels == 3'h1)
        else $error("twelve-bit mode uses more than one channel");
    a_irq_masked_low: assert property (
        !mask_q && !$past(mask_q) |-> !irq)
        else $error("interrupt raised with all sources masked");
    c_power_off: cover property (converter_power_disable);
    c_irq_rise: cover property ($rose(irq));
    c_twelve_mode: cover property (twelve_q);
endmodule : adc_seq_checker
bind adc_seq_core adc_seq_checker i_chk (.clock, .rst, .addr, .wdata, .wr,
    .rd, .rdata, .converter_power_disable, .pin_digital, .port_read_enable,
    .mux_grounded, .route, .irq);

// *** tb/tb_adc_seq_core.sv ***
`timescale 1ns/100ps
module tb_adc_seq_core
    import adc_seq_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        six_input_part = 1'b1;
    logic        converter_power_disable = 1'b0;
    logic        rc_clock_tick = 1'b0;
    logic        sample_start = 1'b0;
    logic        trigger_event = 1'b0;
    logic        conversion_done = 1'b0;
    logic [15:0] rdata;
    logic [5:0]  pin_digital, port_read_enable, mux_grounded, scan_list;
    logic [4:0]  scan_selected;
    logic        conv_clock_tick, end_sample, scan_low_ref, irq;
    route_type   route;
    int          miscompares = 0;
    int          cmp_count = 0;
    adc_seq_core i_dut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .six_input_part, .converter_power_disable, .rc_clock_tick,
        .sample_start, .trigger_event, .conversion_done, .pin_digital,
        .port_read_enable, .mux_grounded, .conv_clock_tick, .end_sample,
        .route, .scan_list, .scan_selected, .scan_low_ref, .irq);
    always #50 clock = ~clock;
    task automatic chk(input string n, input logic [15:0] e, s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // wr_reg, rd_chk and seq_run start on an edge so their changes land by nba there
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
                          input string n);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask : rd_chk
    // outputs are registered behind the registers, so allow three edges
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask : settle
    task automatic seq_run;
        @(posedge clock);
        sample_start <= 1'b1;
        @(posedge clock);
        sample_start <= 1'b0;
        trigger_event <= 1'b1;
        @(posedge clock);
        trigger_event <= 1'b0;
        conversion_done <= 1'b1;
        @(posedge clock);
        conversion_done <= 1'b0;
        settle;
    endtask : seq_run
    task automatic check_regs;
        logic [15:0] m [6] = '{16'h073f, 16'h9fff, 16'h0707, 16'h9f9f,
                               16'h003f, 16'h003f};
        settle;
        chk("reset pins", 16'h0000, {10'h000, pin_digital});
        for (int a = 0; a < 16; a++) rd_chk(a[3:0], 16'h0000, "reset");
        for (int a = 0; a < 6; a++) wr_reg(a[3:0], 16'hffff);
        wr_reg(4'h9, 16'hffff);
        for (int a = 0; a < 6; a++) rd_chk(a[3:0], m[a], "mask");
        rd_chk(4'h9, 16'h0000, "unmapped");
        wr_reg(4'h6, 16'h0080);
        rd_chk(4'h0, 16'h043f, "twelve count");
        wr_reg(4'h6, 16'h0000);
    endtask : check_regs
    task automatic check_pins;
        wr_reg(4'h5, 16'h0015);
        wr_reg(4'h4, 16'h002a);
        settle;
        chk("pin mode", 16'h0015, {10'h000, pin_digital});
        chk("read enable", 16'h0015, {10'h000, port_read_enable});
        chk("mux ground", 16'h0015, {10'h000, mux_grounded});
        chk("scan list", 16'h002a, {10'h000, scan_list});
        @(posedge clock);
        converter_power_disable <= 1'b1;
        settle;
        chk("power off", 16'h003f, {10'h000, pin_digital});
        converter_power_disable <= 1'b0;
        six_input_part <= 1'b0;
        wr_reg(4'h5, 16'h0030);
        rd_chk(4'h5, 16'h0030, "missing pins");
    endtask : check_pins
    task automatic check_routes;
        // scan enable and channel count are left set by check_regs
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h2, 16'h0001);
        settle;
        chk("aux four", 16'h0fde, {1'b0, route.pos1, route.pos2, route.pos3});
        chk("aux neg", 16'h0001, {15'h0000, route.aux_neg_low_ref});
        wr_reg(4'h3, 16'h0005);
        settle;
        chk("main absent", 16'h001e, {11'h000, route.pos0});
        six_input_part <= 1'b1;
        settle;
        chk("aux six", 16'h0c85, {1'b0, route.pos1, route.pos2, route.pos3});
        wr_reg(4'h2, 16'h0000);
        settle;
        chk("aux zero", 16'h0022, {1'b0, route.pos1, route.pos2, route.pos3});
        for (int k = 0; k < 6; k++) begin
            wr_reg(4'h3, k[15:0]);
            settle;
            chk("main", k[15:0], {11'h000, route.pos0});
        end
        for (int c = 0; c < 4; c++) begin
            wr_reg(4'h0, {6'h00, c[1:0], 8'h00});
            settle;
            chk("channels", (c == 0) ? 16'h0001 : (c == 1) ? 16'h0002
                : 16'h0004, {13'h0000, route.channels});
        end
    endtask : check_routes
    task automatic check_clock;
        int n;
        @(posedge clock);
        rc_clock_tick <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            wr_reg(4'h1, (s == 1) ? 16'h8002 : 16'h0002);
            settle;
            n = 0;
            repeat (30) @(negedge clock) n += int'(conv_clock_tick);
            chk("ticks", (s == 1) ? 16'h001e : 16'h000a, n[15:0]);
        end
    endtask : check_clock
    task automatic check_irq;
        wr_reg(4'h0, 16'h0004);
        wr_reg(4'h8, 16'h0001);
        seq_run;
        chk("irq early", 16'h0000, {15'h0000, irq});
        seq_run;
        chk("irq raised", 16'h0001, {15'h0000, irq});
        rd_chk(4'h7, 16'h0001, "status");
        settle;
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        wr_reg(4'h8, 16'h0000);
        seq_run;
        seq_run;
        chk("irq masked", 16'h0000, {15'h0000, irq});
        rd_chk(4'h7, 16'h0001, "masked status");
    endtask : check_irq
    // four sequences ran before, so the scan pointer sits on input 4
    task automatic check_auto;
        int n;
        @(posedge clock);
        six_input_part <= 1'b0;
        wr_reg(4'h4, 16'h0030);
        wr_reg(4'h0, 16'h0400);
        wr_reg(4'h6, 16'h0070);
        wr_reg(4'h1, 16'h8202);
        settle;
        chk("low ref", 16'h0001, {15'h0000, scan_low_ref});
        chk("scan sel", 16'h001f, {11'h000, scan_selected});
        @(posedge clock);
        sample_start <= 1'b1;
        @(posedge clock);
        sample_start <= 1'b0;
        n = 0;
        while (n < 20 && end_sample !== 1'b1) begin
            @(negedge clock);
            n++;
        end
        chk("sample len", 16'h0003, n[15:0]);
        @(posedge clock);
        conversion_done <= 1'b1;
        @(posedge clock);
        conversion_done <= 1'b0;
        rd_chk(4'h7, 16'h0003, "miss status");
    endtask : check_auto
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        check_regs;
        check_pins;
        check_routes;
        check_clock;
        check_irq;
        check_auto;
        finish_test;
    end
endmodule : tb_adc_seq_core
